// >>> design/ext_bus_defines.svh
// constants for the external bus master control block
// assumes nothing beyond a SystemVerilog compiler; definitions only
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
// attribute / row strobe lines
`define ATTR_W 4
// width of the programmed minimum wait count
`define WAIT_W 4
// width of the one-hot arbitration state
`define ST_W 6
// programmed minimum value that marks a zero-wait cycle
`define WAIT_ZERO 4'h0
// settings flags crossing into the link domain, ahead of polarity and minimum
`define CFG_FLAGS 6
// synchronised pins sit at their idle, deasserted level out of reset
`define PINS_IDLE 3'h7
`endif

// >>> design/ext_bus_master_control.sv
// control side of an external memory expansion port: strobes, wait states,
// request / grant / busy arbitration, parking, lock, column strobe, bus clock
// assumes pins on the link clock domain, requests from core_clk logic
// How it works
// - attribute lines active only during an access, polarity programmable
// - read strobe asserted while owner, floated otherwise
// - write strobe asserted while owner, floated otherwise
// - acknowledge ignored when not owner or no access running
// - cycle ends one clock after acknowledge seen; no limit on waits
// - waits are the larger of programmed minimum and acknowledge delay, or the minimum alone for zero-minimum and DRAM cycles
// - acknowledge sampled synchronously or deglitched, per select bit
// - request asserted only while external bus is needed
// - request-hold bit keeps request asserted with nothing pending
// - reset deasserts request and returns arbitration to slave
// - after grant, wait busy deasserted, then own and drive busy
// - grant removal releases bus at end of current cycle
// - owner may park, keeping busy, and reuse bus without arbitration
// - busy released by driving high one cycle, then floating
// - lock from start of read through end of write in read-modify-write
// - lock only for bit-modify accesses to external memory
// - lock-hold bit asserts lock
// - column strobe used as owner, floated if not owner and enable clear
// - bus clock driven as owner with bus clock enable set
// - inverse bus clock is exact inverse, driven only as owner
// - low power releases ownership and floats port outputs, the column strobe only with its enable bit clear
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
module ext_bus_master_control
  import ext_bus_pkg::*;
#(
  parameter int ATTR_W = `ATTR_W,
  parameter int WAIT_W = `WAIT_W
) (
  // clocks and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  // access request, core_clk domain
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_rmw,
  input wire logic req_dram,
  input wire logic [ATTR_W-1:0] req_attr,
  output logic req_ready_q,
  output logic req_done_q,
  output logic owner_q,
  // configuration levels, quasi-static
  input wire logic request_hold_bit,
  input wire logic lock_hold_bit,
  input wire logic ack_sync_select_bit,
  input wire logic bus_clock_enable_bit,
  input wire logic ownership_enable_bit,
  input wire logic low_power,
  input wire logic [ATTR_W-1:0] attr_polarity,
  input wire logic [WAIT_W-1:0] min_wait,
  // external bus pins, link_clk domain
  input wire logic transfer_ack_n,
  input wire logic bus_grant_n,
  input wire logic bus_busy_n_in,
  output logic [ATTR_W-1:0] attr_or_row_strobe_q,
  output logic attr_oe_q,
  output logic read_strobe_n_q,
  output logic write_strobe_n_q,
  output logic strobe_oe_q,
  output logic bus_request_n_q,
  output logic bus_busy_n_q,
  output logic bus_busy_oe_q,
  output logic bus_lock_n_q,
  output logic column_strobe_n_q,
  output logic column_strobe_oe_q,
  output logic bus_clock_q,
  output logic bus_clock_oe_q,
  output logic bus_clock_n_q,
  output logic bus_clock_n_oe_q
);
  localparam int CFG_W = `CFG_FLAGS + ATTR_W + WAIT_W;
  // core_clk domain
  logic req_tgl_q, write_q, rmw_q, dram_q;
  logic [ATTR_W-1:0] attr_q;
  logic done_s1_q, done_s2_q, done_s3_q, own_s1_q, done_seen;
  // link-side flops sampled here, declared ahead of their first use
  logic done_tgl_q, own_link_q;
  // link completion arrives as a toggle
  assign done_seen = done_s2_q ^ done_s3_q;
  // request capture; fields stay frozen until the link reports completion,
  // which is what makes reading them across the crossing safe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_ready_q <= 1'b1;
      req_tgl_q <= 1'b0;
      write_q <= 1'b0;
      rmw_q <= 1'b0;
      dram_q <= 1'b0;
      attr_q <= '0;
    end else if (req_valid && req_ready_q) begin
      req_ready_q <= 1'b0;
      req_tgl_q <= ~req_tgl_q;
      write_q <= req_write;
      rmw_q <= req_rmw;
      dram_q <= req_dram;
      attr_q <= req_attr;
    end else if (done_seen) begin
      req_ready_q <= 1'b1;
    end
  end

  // completion and ownership crossing back into core_clk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      req_done_q <= 1'b0;
      own_s1_q <= 1'b0;
      owner_q <= 1'b0;
    end else begin
      done_s1_q <= done_tgl_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      req_done_q <= done_seen;
      own_s1_q <= own_link_q;
      owner_q <= own_s1_q;
    end
  end
  // link_clk domain
  logic [CFG_W-1:0] cfg_s1_q, cfg_s2_q;
  logic [2:0] pin_s1_q, pin_s2_q;
  logic ta_s3_q, rq_s1_q, rq_s2_q, rq_s3_q, pend_q, second_q, second_d;
  logic [WAIT_W-1:0] wcnt_q, min_w;
  arb_state_t state_q, state_d;
  logic hold_rq, hold_lk, ack_async, clk_en, own_en, lowp;
  logic [ATTR_W-1:0] pol;
  logic ta_s, bg_s, bb_s, new_req, ack_n_eff, finish;
  logic access_d, owner_d, need_d, cur_write;
  assign {hold_rq, hold_lk, ack_async, clk_en, own_en, lowp, pol, min_w} = cfg_s2_q;
  assign {ta_s, bg_s, bb_s} = pin_s2_q;
  assign new_req = rq_s2_q ^ rq_s3_q;
  // two-flop synchronisers for settings, pins and the request toggle
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
      pin_s1_q <= `PINS_IDLE;
      pin_s2_q <= `PINS_IDLE;
      ta_s3_q <= 1'b1;
      rq_s1_q <= 1'b0;
      rq_s2_q <= 1'b0;
      rq_s3_q <= 1'b0;
    end else begin
      cfg_s1_q <= {request_hold_bit, lock_hold_bit, ack_sync_select_bit,
                   bus_clock_enable_bit, ownership_enable_bit, low_power,
                   attr_polarity, min_wait};
      cfg_s2_q <= cfg_s1_q;
      pin_s1_q <= {transfer_ack_n, bus_grant_n, bus_busy_n_in};
      pin_s2_q <= pin_s1_q;
      ta_s3_q <= ta_s;
      rq_s1_q <= req_tgl_q;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
    end
  end

  // asynchronous mode wants two agreeing samples, trading a cycle of
  // latency for immunity to a runt acknowledge
  assign ack_n_eff = ack_async ? (ta_s | ta_s3_q) : ta_s;

  // zero-wait and DRAM cycles never look at the acknowledge
  assign finish = (wcnt_q >= min_w) &&
                  ((min_w == `WAIT_ZERO) || dram_q || !ack_n_eff);

  // next state of the arbitration and access sequencer
  always_comb begin
    state_d = state_q;
    second_d = second_q;
    case (state_q)
      ST_SLAVE: begin
        if (!bg_s && !lowp && (pend_q || hold_rq)) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (bg_s) begin
          state_d = ST_SLAVE;
        end else if (bb_s) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (bg_s || lowp) begin
          state_d = ST_REL;
        end else if (pend_q) begin
          state_d = ST_XFER;
        end
      end
      ST_XFER: begin
        if (finish) begin
          state_d = ST_END;
        end
      end
      ST_END: begin
        if (rmw_q && !second_q) begin
          state_d = ST_XFER;
          second_d = 1'b1;
        end else begin
          second_d = 1'b0;
          state_d = (bg_s || lowp) ? ST_REL : ST_IDLE;
        end
      end
      ST_REL: begin
        state_d = ST_SLAVE;
      end
      default: begin
        state_d = ST_SLAVE;
        second_d = 1'b0;
      end
    endcase
  end

  assign access_d = (state_d == ST_XFER) || (state_d == ST_END);
  assign owner_d = access_d || (state_d == ST_IDLE);
  assign need_d = pend_q || hold_rq || access_d;
  assign cur_write = rmw_q ? second_d : write_q;

  // sequencer state; reset lands in the slave state
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_SLAVE;
      second_q <= 1'b0;
      own_link_q <= 1'b0;
    end else begin
      state_q <= state_d;
      second_q <= second_d;
      own_link_q <= owner_d;
    end
  end

  // wait counter saturates, so acknowledge can stretch a cycle forever
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      wcnt_q <= '0;
    end else if (state_q != ST_XFER || state_d != ST_XFER) begin
      wcnt_q <= '0;
    end else if (wcnt_q != {WAIT_W{1'b1}}) begin
      wcnt_q <= wcnt_q + 1'b1;
    end
  end

  // pending request and the completion toggle toward core_clk
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      done_tgl_q <= 1'b0;
    end else begin
      if (new_req) begin
        pend_q <= 1'b1;
      end else if (state_q == ST_IDLE && state_d == ST_XFER) begin
        pend_q <= 1'b0;
      end
      if (state_q == ST_END && state_d != ST_XFER) begin
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  // request and lock; reset holds both deasserted
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      bus_request_n_q <= 1'b1;
      bus_lock_n_q <= 1'b1;
    end else begin
      bus_request_n_q <= ~need_d;
      bus_lock_n_q <= ~(hold_lk || (access_d && rmw_q));
    end
  end

  // attributes and strobes, inactive between accesses, floated off-bus
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      attr_or_row_strobe_q <= '0;
      attr_oe_q <= 1'b0;
      read_strobe_n_q <= 1'b1;
      write_strobe_n_q <= 1'b1;
      strobe_oe_q <= 1'b0;
    end else begin
      attr_or_row_strobe_q <= ~((access_d ? attr_q : '0) ^ pol);
      attr_oe_q <= owner_d;
      read_strobe_n_q <= ~(access_d && !cur_write);
      write_strobe_n_q <= ~(access_d && cur_write);
      strobe_oe_q <= owner_d;
    end
  end

  // busy is driven low as owner, driven high for one cycle on release
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      bus_busy_n_q <= 1'b1;
      bus_busy_oe_q <= 1'b0;
    end else begin
      bus_busy_n_q <= ~owner_d;
      bus_busy_oe_q <= owner_d || (state_d == ST_REL);
    end
  end

  // column strobe; kept driven off-bus only when the enable bit asks
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      column_strobe_n_q <= 1'b1;
      column_strobe_oe_q <= 1'b0;
    end else begin
      column_strobe_n_q <= ~(access_d && dram_q);
      column_strobe_oe_q <= owner_d || own_en;
    end
  end

  // bus clock at half the link rate; the quarter-period lead needs a PLL
  // and is not reproduced here
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      bus_clock_q <= 1'b0;
      bus_clock_n_q <= 1'b1;
      bus_clock_oe_q <= 1'b0;
      bus_clock_n_oe_q <= 1'b0;
    end else begin
      if (owner_d && clk_en) begin
        bus_clock_q <= ~bus_clock_q;
        bus_clock_n_q <= bus_clock_q;
      end else begin
        bus_clock_q <= 1'b0;
        bus_clock_n_q <= 1'b1;
      end
      bus_clock_oe_q <= owner_d && clk_en;
      bus_clock_n_oe_q <= owner_d;
    end
  end

  // checks, all on the link clock
  slave_no_strobe_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_SLAVE) |-> !strobe_oe_q && read_strobe_n_q)
    else $error("strobes driven while slave");
  wait_no_write_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_WAIT) |-> !strobe_oe_q && write_strobe_n_q)
    else $error("write strobe driven before ownership");
  idle_ack_ignored_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_IDLE && !pend_q && !ack_n_eff) |=> (state_q inside {ST_IDLE, ST_REL}))
    else $error("acknowledge acted on with no access");
  end_then_drop_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_END && !rmw_q) |=> read_strobe_n_q && write_strobe_n_q)
    else $error("strobe held after cycle end");
  min_wait_kept_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_XFER && state_d == ST_END) |-> (wcnt_q >= min_w))
    else $error("cycle shorter than programmed waits");
  hold_request_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (hold_rq && $past(hold_rq) && state_q == ST_IDLE) |-> !bus_request_n_q)
    else $error("request dropped under hold");
  busy_wait_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_WAIT && !bb_s) |=> !bus_busy_oe_q)
    else $error("busy taken while another master busy");
  busy_release_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_REL) |-> (bus_busy_oe_q && bus_busy_n_q) ##1 !bus_busy_oe_q)
    else $error("busy not released high then floated");
  rmw_lock_gap_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_END && rmw_q && !second_q) |-> !bus_lock_n_q ##1
    (!bus_lock_n_q && !write_strobe_n_q))
    else $error("lock lost between read and write");
  slave_unlocked_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_SLAVE && !hold_lk && !$past(hold_lk)) |-> bus_lock_n_q)
    else $error("lock asserted without cause");
  cas_float_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_SLAVE && !own_en && !$past(own_en)) |-> !column_strobe_oe_q)
    else $error("column strobe driven off-bus");
  clock_inverse_a: assert property (
    @(posedge link_clk) disable iff (rst)
    bus_clock_n_q != bus_clock_q)
    else $error("inverse bus clock not inverse");
  rmw_done_c: cover property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_END && rmw_q && second_q));
  parked_c: cover property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_IDLE && !pend_q && bus_request_n_q));
  stretched_c: cover property (
    @(posedge link_clk) disable iff (rst)
    (state_q == ST_XFER && wcnt_q > min_w && ack_n_eff));
endmodule

// >>> design/ext_bus_pkg.sv
// types shared by the external bus master control block
// assumes the defines header sits on the include path
`include "ext_bus_defines.svh"
package ext_bus_pkg;
  // arbitration and access sequencer, one-hot
  typedef enum logic [`ST_W-1:0] {
    ST_SLAVE = 6'h01,
    ST_WAIT = 6'h02,
    ST_IDLE = 6'h04,
    ST_XFER = 6'h08,
    ST_END = 6'h10,
    ST_REL = 6'h20
  } arb_state_t;
endpackage

// >>> tb/ext_bus_far_side.sv
// far side model: bus arbiter, a second master and memory acknowledge
// assumes active-low strobes from the block and a pulled-up busy line
`timescale 1ns/1ps
module ext_bus_far_side (
  // clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // bench controls
  input wire logic grant_en,
  input wire logic other_busy,
  input wire logic [7:0] ack_delay,
  // strobes from the block
  input wire logic read_strobe_n_q,
  input wire logic write_strobe_n_q,
  // pins toward the block
  output logic transfer_ack_n,
  output logic bus_grant_n,
  output logic other_busy_n
);
  logic [7:0] wait_q;
  logic [1:0] cyc_q;
  // grant and foreign busy only move on the link clock edge
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      bus_grant_n <= 1'b1;
      other_busy_n <= 1'b1;
    end else begin
      bus_grant_n <= ~grant_en;
      other_busy_n <= ~other_busy;
    end
  end
  // ack low after ack_delay strobe cycles; high again when a cycle ends,
  // so a cycle after idle strobes starts with the ack deasserted; a read swapped straight to a write deasserts it on the first edge that sees the swap
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 8'h00;
      cyc_q <= 2'h3;
      transfer_ack_n <= 1'b1;
    end else begin
      cyc_q <= {read_strobe_n_q, write_strobe_n_q};
      if ((&cyc_q) || cyc_q != {read_strobe_n_q, write_strobe_n_q}) begin
        wait_q <= 8'h00;
        transfer_ack_n <= 1'b1;
      end else begin
        wait_q <= wait_q + 8'h01;
        transfer_ack_n <= ~(wait_q >= ack_delay);
      end
    end
  end
endmodule

// >>> tb/external_bus_master_control_bench.sv
// bench for the external bus master control block with a far side model
// assumes the far side model file is compiled first
`timescale 1ns/1ps
module external_bus_master_control_bench;
  import ext_bus_pkg::*;
  logic core_clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_rmw = 1'b0, req_dram = 1'b0;
  logic [3:0] req_attr = 4'h0, attr_polarity = 4'h5, min_wait = 4'h0, cur_attr = 4'h0;
  logic request_hold_bit = 1'b0, lock_hold_bit = 1'b0, ack_sync_select_bit = 1'b0;
  logic bus_clock_enable_bit = 1'b1, ownership_enable_bit = 1'b1, low_power = 1'b0;
  logic grant_en = 1'b0, other_busy = 1'b0;
  logic [7:0] ack_delay = 8'h00;
  logic transfer_ack_n, bus_grant_n, bus_busy_n_in, other_busy_n;
  logic req_ready_q, req_done_q, owner_q, attr_oe_q, read_strobe_n_q, write_strobe_n_q;
  logic [3:0] attr_or_row_strobe_q;
  logic strobe_oe_q, bus_request_n_q, bus_busy_n_q, bus_busy_oe_q, bus_lock_n_q;
  logic column_strobe_n_q, column_strobe_oe_q, bus_clock_q, bus_clock_oe_q;
  logic bus_clock_n_q, bus_clock_n_oe_q, busy_oe_p, busy_v_p, clk_oe_p, clk_v_p;
  int error_cnt = 0, n_checks = 0, cyc = 0, rd_cyc, wr_cyc, lk_cyc, cas_cyc;
  // clocks of unrelated phase; busy has a pull-up and a second master
  always #50 core_clk = ~core_clk;
  always #24 link_clk = ~link_clk;
  assign bus_busy_n_in = (bus_busy_oe_q ? bus_busy_n_q : 1'b1) & other_busy_n;
  ext_bus_master_control DUT (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
    .req_valid(req_valid), .req_write(req_write), .req_rmw(req_rmw), .req_dram(req_dram),
    .req_attr(req_attr), .req_ready_q(req_ready_q), .req_done_q(req_done_q),
    .owner_q(owner_q), .request_hold_bit(request_hold_bit), .lock_hold_bit(lock_hold_bit),
    .ack_sync_select_bit(ack_sync_select_bit), .bus_clock_enable_bit(bus_clock_enable_bit),
    .ownership_enable_bit(ownership_enable_bit), .low_power(low_power),
    .attr_polarity(attr_polarity), .min_wait(min_wait), .transfer_ack_n(transfer_ack_n),
    .bus_grant_n(bus_grant_n), .bus_busy_n_in(bus_busy_n_in),
    .attr_or_row_strobe_q(attr_or_row_strobe_q), .attr_oe_q(attr_oe_q),
    .read_strobe_n_q(read_strobe_n_q), .write_strobe_n_q(write_strobe_n_q),
    .strobe_oe_q(strobe_oe_q), .bus_request_n_q(bus_request_n_q),
    .bus_busy_n_q(bus_busy_n_q), .bus_busy_oe_q(bus_busy_oe_q), .bus_lock_n_q(bus_lock_n_q),
    .column_strobe_n_q(column_strobe_n_q), .column_strobe_oe_q(column_strobe_oe_q),
    .bus_clock_q(bus_clock_q), .bus_clock_oe_q(bus_clock_oe_q),
    .bus_clock_n_q(bus_clock_n_q), .bus_clock_n_oe_q(bus_clock_n_oe_q));
  ext_bus_far_side far_side (.link_clk(link_clk), .rst(rst), .grant_en(grant_en),
    .other_busy(other_busy), .ack_delay(ack_delay), .read_strobe_n_q(read_strobe_n_q),
    .write_strobe_n_q(write_strobe_n_q), .transfer_ack_n(transfer_ack_n),
    .bus_grant_n(bus_grant_n), .other_busy_n(other_busy_n));
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // pin monitor on the link clock: cycle counts and per-edge relations
  always @(posedge link_clk) begin
    if (strobe_oe_q && !read_strobe_n_q) rd_cyc++;
    if (strobe_oe_q && !write_strobe_n_q) wr_cyc++;
    if (!bus_lock_n_q) lk_cyc++;
    if (column_strobe_oe_q && !column_strobe_n_q) cas_cyc++;
    if (strobe_oe_q && !(read_strobe_n_q && write_strobe_n_q))
      chk(attr_or_row_strobe_q === ~(cur_attr ^ attr_polarity), "attr level");
    if (bus_clock_oe_q) chk(bus_clock_n_q === ~bus_clock_q, "inverse clock");
    if (busy_oe_p && !bus_busy_oe_q) chk(busy_v_p === 1'b1, "busy not driven high");
    busy_oe_p = bus_busy_oe_q;
    busy_v_p = bus_busy_n_q;
    // a running bus clock flips on every rising link edge while enabled
    if (clk_oe_p && bus_clock_oe_q) chk(bus_clock_q !== clk_v_p, "bus clock stuck");
    clk_oe_p = bus_clock_oe_q;
    clk_v_p = bus_clock_q;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t run timed out", $time);
      wrap_up();
    end
  end
  // one request, counters cleared off any link edge, waits for done
  task automatic access(input logic wr, input logic rmw, input logic dram,
                        input logic [3:0] attr);
    int n;
    @(posedge core_clk);
    {rd_cyc, wr_cyc, lk_cyc, cas_cyc} = '0;
    cur_attr = attr;
    @(negedge core_clk);
    chk(req_ready_q === 1'b1, "not ready");
    {req_write, req_rmw, req_dram, req_attr} = {wr, rmw, dram, attr};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (req_done_q !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 400, "access never finished");
    chk(attr_oe_q === 1'b0 || attr_or_row_strobe_q === ~attr_polarity, "attr held");
  endtask
  task automatic arbitrate_read();
    other_busy = 1'b1;
    grant_en = 1'b1;
    fork
      access(1'b0, 1'b0, 1'b0, 4'h3);
      begin
        repeat (30) @(negedge core_clk);
        chk(owner_q === 1'b0, "owned while busy");
        chk(bus_request_n_q === 1'b0, "no request");
        other_busy = 1'b0;
      end
    join
    chk(rd_cyc == 2 && wr_cyc == 0, "zero wait read length");
    chk(lk_cyc == 0, "lock on plain read");
    repeat (10) @(negedge core_clk);
    chk(bus_busy_oe_q === 1'b1 && bus_busy_n_q === 1'b0, "not parked");
    chk(bus_request_n_q === 1'b1, "request kept");
    chk(bus_clock_oe_q === 1'b1, "bus clock off");
  endtask
  // wait states from the minimum or the acknowledge, both sampling modes
  task automatic wait_states();
    int lo;
    for (int i = 0; i < 4; i++) begin
      ack_sync_select_bit = i[0];
      min_wait = (i < 2) ? 4'h2 : 4'h5;
      ack_delay = (i < 2) ? 8'h06 : 8'h00;
      lo = (min_wait + 1 > ack_delay + 2) ? min_wait + 1 : ack_delay + 2;
      access(1'b1, 1'b0, 1'b0, 4'h9);
      chk(wr_cyc >= lo && wr_cyc <= lo + 8, "wait state count");
    end
    {min_wait, ack_delay} = '0;
  endtask
  task automatic locked_and_dram();
    access(1'b0, 1'b1, 1'b0, 4'h6);
    chk(rd_cyc > 0 && wr_cyc > 0 && lk_cyc >= rd_cyc + wr_cyc, "lock span");
    chk(bus_lock_n_q === 1'b1, "lock after rmw");
    lock_hold_bit = 1'b1;
    repeat (10) @(negedge core_clk);
    chk(bus_lock_n_q === 1'b0, "lock hold");
    lock_hold_bit = 1'b0;
    min_wait = 4'h1;
    access(1'b0, 1'b0, 1'b1, 4'h1);
    chk(cas_cyc > 0 && rd_cyc <= 10, "column strobe access");
    min_wait = 4'h0;
  endtask
  task automatic hold_power_release();
    grant_en = 1'b0;
    repeat (20) @(negedge core_clk);
    chk(owner_q === 1'b0 && strobe_oe_q === 1'b0, "kept bus");
    chk(bus_busy_oe_q === 1'b0 && bus_clock_n_oe_q === 1'b0, "pins driven");
    ownership_enable_bit = 1'b0;
    repeat (5) @(negedge core_clk);
    chk(column_strobe_oe_q === 1'b0, "column strobe driven off-bus");
    request_hold_bit = 1'b1;
    repeat (10) @(negedge core_clk);
    chk(bus_request_n_q === 1'b0, "request hold");
    grant_en = 1'b1;
    repeat (30) @(negedge core_clk);
    chk(owner_q === 1'b1, "no ownership");
    chk(column_strobe_oe_q === 1'b1, "column strobe floated as owner");
    bus_clock_enable_bit = 1'b0;
    repeat (5) @(negedge core_clk);
    chk(bus_clock_oe_q === 1'b0 && bus_clock_n_oe_q === 1'b1, "bus clock enable");
    bus_clock_enable_bit = 1'b1;
    repeat (5) @(negedge core_clk);
    low_power = 1'b1;
    repeat (30) @(negedge core_clk);
    chk(owner_q === 1'b0 && attr_oe_q === 1'b0, "low power owner");
    chk(bus_busy_oe_q === 1'b0 && bus_clock_oe_q === 1'b0, "low power pins");
    {low_power, request_hold_bit} = '0;
    repeat (10) @(negedge core_clk);
    chk(bus_request_n_q === 1'b1, "request stuck");
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    chk(bus_request_n_q === 1'b1 && bus_lock_n_q === 1'b1, "reset levels");
    chk(owner_q === 1'b0 && bus_busy_oe_q === 1'b0, "reset owner");
    repeat (3) @(negedge core_clk);
    arbitrate_read();
    wait_states();
    locked_and_dram();
    hold_power_release();
    wrap_up();
  end
endmodule
